// ===== design/host_bus_mode_select.sv
`timescale 1ns/10ps

// Operation
// - Straps 1,1: big-endian host, fixed synchronous timing, no ready handshake.
// - Big-endian modes use eight separate data pins and ten address pins.
// - Straps 1,0: ready handshake marks completion; host stretches access until ready.
// - Straps 0,1: little-endian host on multiplexed bus, fixed timing, no ready.
// - Multiplexed mode latches low address byte from shared bus on address strobe.
// - Multiplexed mode decodes its own select; responds only at address 00000000xx.
// - In multiplexed mode two lowest address pins pick one of four internal windows.
// - Format strap picks byte order; timing strap picks fixed or ready timing.
// - Big-endian word access to 16-bit parameter registers is byte swapped.
// - Straps 0,0: little-endian asynchronous with ready, decoder off, external select.
module host_bus_mode_select (
  // Clock and reset.
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Configuration straps.
  input  wire logic                                format_strap_i,
  input  wire logic                                timing_strap_i,
  // Host bus strobes and select.
  input  wire logic                                device_select_n_i,
  input  wire logic                                ale_i,
  input  wire logic                                rd_n_i,
  input  wire logic                                wr_n_i,
  // Host address and data pins.
  input  wire logic [host_port_pkg::ADDR_W-1:0]    address_pins_i,
  input  wire logic [host_port_pkg::DATA_W-1:0]    data_pins_i,
  output      logic [host_port_pkg::DATA_W-1:0]    data_pins_o,
  output      logic                                data_pins_oe_o,
  // Open-drain ready toward the host.
  output      logic                                cycle_ready_n_o,
  output      logic                                cycle_ready_n_oe_o,
  // Internal register and memory side.
  output      logic                                req_o,
  output      host_port_pkg::host_req_s            req_data_o,
  input  wire logic                                param16_i,
  input  wire logic [host_port_pkg::DATA_W-1:0]    rdata_i,
  // Sampled strap setting.
  output      host_port_pkg::mode_s                mode_o
);

  // Synchroniser stages for every host pin.
  logic [host_port_pkg::SYNC_W-1:0] meta_q;
  logic [host_port_pkg::SYNC_W-1:0] pins_q;

  // Sampled straps, address latch and sequencer.
  host_port_pkg::mode_s             mode_q;
  logic [host_port_pkg::DATA_W-1:0] addr_latch_q;
  host_port_pkg::acc_state_e        state_q;
  host_port_pkg::acc_state_e        state_d;
  host_port_pkg::host_req_s         req_data_q;
  logic                             req_q;
  logic [host_port_pkg::DATA_W-1:0] dout_q;
  logic                             dout_oe_q;
  logic                             rdy_oe_q;
  logic                             raw_a0_q;

  // Named views of the synchronised pins.
  wire logic [host_port_pkg::DATA_W-1:0] dat_s = pins_q[host_port_pkg::SY_DATA +: 8];
  wire logic [host_port_pkg::ADDR_W-1:0] adr_s = pins_q[host_port_pkg::SY_ADDR +: 10];
  wire logic rd_s  = ~pins_q[host_port_pkg::SY_RD_N];
  wire logic wr_s  = ~pins_q[host_port_pkg::SY_WR_N];
  wire logic ale_s = pins_q[host_port_pkg::SY_ALE];
  wire logic esel_s = ~pins_q[host_port_pkg::SY_SEL_N];

  // Builds the internal address; in multiplexed mode the window bits come from address pins 1 and 0, the low byte from the latch.
  function automatic logic [host_port_pkg::ADDR_W-1:0] int_addr(
    input logic                             mux,
    input logic [host_port_pkg::ADDR_W-1:0] pins,
    input logic [host_port_pkg::DATA_W-1:0] lat
  );
    logic [host_port_pkg::ADDR_W-1:0] a;
    a = mux ? {pins[1:0], lat} : pins;
    return a;
  endfunction : int_addr

  // Mode decoding and select generation.
  wire logic mux_w   = (mode_q.format == host_port_pkg::FORMAT_LITTLE_ENDIAN) &&
                       (mode_q.timing == host_port_pkg::TIMING_SYNC);
  wire logic async_w = (mode_q.timing == host_port_pkg::TIMING_ASYNC);
  wire logic dec_w   = (adr_s[host_port_pkg::ADDR_W-1:host_port_pkg::DEC_LSB] ==
                        host_port_pkg::DEC_MATCH);
  wire logic sel_w   = mux_w ? dec_w : esel_s;
  wire logic strb_w  = rd_s | wr_s;
  wire logic go_w    = strb_w & sel_w;
  wire logic [host_port_pkg::ADDR_W-1:0] raw_w = int_addr(mux_w, adr_s, addr_latch_q);
  wire logic swap_w  = (mode_q.format == host_port_pkg::FORMAT_BIG_ENDIAN) & param16_i;
  wire logic [host_port_pkg::ADDR_W-1:0] iad_w = {raw_w[9:1], raw_w[0] ^ swap_w};

  // Next state of the access sequencer.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      host_port_pkg::ST_IDLE: if (go_w) state_d = host_port_pkg::ST_ACT;
      host_port_pkg::ST_ACT:  state_d = host_port_pkg::ST_HOLD;
      host_port_pkg::ST_HOLD: if (!strb_w) state_d = host_port_pkg::ST_IDLE;
      default:                state_d = host_port_pkg::ST_IDLE;
    endcase
  end

  // Two-stage synchroniser for all pins from the host domain.
  // The strap bits keep moving during reset so that the sampled setting is the live one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= {format_strap_i, timing_strap_i,
                 host_port_pkg::SYNC_RST[host_port_pkg::SY_TIMING-1:0]};
      pins_q <= {meta_q[host_port_pkg::SY_FORMAT:host_port_pkg::SY_TIMING],
                 host_port_pkg::SYNC_RST[host_port_pkg::SY_TIMING-1:0]};
    end
    else
    begin
      meta_q <= {format_strap_i, timing_strap_i, device_select_n_i, ale_i,
                 rd_n_i, wr_n_i, address_pins_i, data_pins_i};
      pins_q <= meta_q;
    end
  end

  // Straps follow the pins while reset is held and freeze after release.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_q <= {pins_q[host_port_pkg::SY_FORMAT], pins_q[host_port_pkg::SY_TIMING]};
  end

  // Low address byte is captured from the shared bus while the strobe is high.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr_latch_q <= 8'h00;
    else if (mux_w && ale_s)
      addr_latch_q <= dat_s;
  end

  // Sequencer and request register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= host_port_pkg::ST_IDLE;
      req_q      <= 1'b0;
      req_data_q <= host_port_pkg::REQ_RST;
      raw_a0_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q   <= (state_q == host_port_pkg::ST_IDLE) && go_w;
      if ((state_q == host_port_pkg::ST_IDLE) && go_w)
      begin
        req_data_q <= '{we: wr_s, addr: iad_w, wdata: dat_s};
        raw_a0_q   <= raw_w[0];
      end
    end
  end

  // Read data and pin drive: data pins released outside a selected read, ready outside a selected access.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_q    <= 8'h00;
      dout_oe_q <= 1'b0;
      rdy_oe_q  <= 1'b0;
    end
    else
    begin
      if (state_q == host_port_pkg::ST_ACT)
        dout_q <= rdata_i;
      dout_oe_q <= (state_d == host_port_pkg::ST_HOLD) && !req_data_q.we;
      rdy_oe_q  <= (state_d == host_port_pkg::ST_HOLD) && async_w;
    end
  end

  // Outputs come straight from flip-flops; the ready level is a constant low.
  assign data_pins_o        = dout_q;
  assign data_pins_oe_o     = dout_oe_q;
  assign cycle_ready_n_o    = 1'b0;
  assign cycle_ready_n_oe_o = rdy_oe_q;
  assign req_o              = req_q;
  assign req_data_o         = req_data_q;
  assign mode_o             = mode_q;

  // Checks on the sequencer and its outputs.
  sequence s_start;
    (state_q == host_port_pkg::ST_IDLE) && go_w;
  endsequence

  sequence s_issue;
    req_q ##1 (state_q == host_port_pkg::ST_HOLD);
  endsequence

  access_flow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start |=> s_issue)
    else $error("selected strobe did not issue one request");

  req_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_q |=> !req_q)
    else $error("request longer than one cycle");

  no_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == host_port_pkg::ST_IDLE) && !sel_w |=> !req_q)
    else $error("request issued while not selected");

  no_ready_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !async_w |-> !cycle_ready_n_oe_o)
    else $error("ready driven in synchronous mode");

  ready_async_a: assert property (@(posedge clk_i) disable iff (rst_i)
    async_w && (state_q == host_port_pkg::ST_ACT) |=> cycle_ready_n_oe_o && !cycle_ready_n_o)
    else $error("ready missing in asynchronous mode");

  drive_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    data_pins_oe_o |-> (state_q == host_port_pkg::ST_HOLD) && !req_data_q.we)
    else $error("data pins driven outside a read");

  strap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(mode_q))
    else $error("strap setting changed in operation");

  latch_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mux_w && ale_s |=> addr_latch_q == $past(dat_s))
    else $error("address latch missed the shared bus");

  byte_swap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start ##0 swap_w |=> req_data_q.addr[0] != raw_a0_q)
    else $error("word access not byte swapped");

endmodule : host_bus_mode_select

// ===== inc/host_port_pkg.sv
package host_port_pkg;

  // Strap encodings for the byte format and the bus timing.
  localparam logic FORMAT_BIG_ENDIAN    = 1'b1;
  localparam logic FORMAT_LITTLE_ENDIAN = 1'b0;
  localparam logic TIMING_SYNC          = 1'b1;
  localparam logic TIMING_ASYNC         = 1'b0;

  // Widths of the host pins.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int SYNC_W = 2 + 4 + ADDR_W + DATA_W;

  // Bit positions inside the synchroniser vector.
  localparam int SY_DATA   = 0;
  localparam int SY_ADDR   = SY_DATA + DATA_W;
  localparam int SY_WR_N   = SY_ADDR + ADDR_W;
  localparam int SY_RD_N   = SY_WR_N + 1;
  localparam int SY_ALE    = SY_RD_N + 1;
  localparam int SY_SEL_N  = SY_ALE + 1;
  localparam int SY_TIMING = SY_SEL_N + 1;
  localparam int SY_FORMAT = SY_TIMING + 1;

  // Idle pin levels loaded into the synchroniser at reset: select and both strobes high,
  // address latch strobe low. The strap bits are not reset, so they keep flowing.
  localparam logic [SYNC_W-1:0] SYNC_RST = 24'h2C0000;

  // Fixed decode: pin bits 9 to 2 must be zero in multiplexed mode.
  localparam int                DEC_LSB = 2;
  localparam logic [ADDR_W-1:DEC_LSB] DEC_MATCH = 8'h00;

  // Sampled strap setting.
  typedef struct packed {
    logic format;
    logic timing;
  } mode_s;

  localparam mode_s MODE_RST = 2'h3;

  // One access toward the internal register and memory space.
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

  localparam host_req_s REQ_RST = 19'h00000;

  // Access sequencer states; idle to active and active to hold change one bit each, hold back to idle changes both.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACT  = 2'h1,
    ST_HOLD = 2'h3
  } acc_state_e;

endpackage : host_port_pkg

// ===== sim/host_cpu_model.sv
`timescale 1ns/10ps

// Behavioural host microcontroller that drives the parallel bus of the port.
module host_cpu_model (
  // Clock and bus levels seen by the host.
  input  wire logic       clk_i,
  input  wire logic       ready_n_i,
  input  wire logic [7:0] bus_i,
  // Select, strobes and pins driven by the host.
  output      logic       sel_n_o,
  output      logic       ale_o,
  output      logic       rd_n_o,
  output      logic       wr_n_o,
  output      logic [9:0] addr_o,
  output      logic [7:0] data_o
);

  // Idle levels: strobes inactive, device not selected.
  initial
  begin
    {sel_n_o, ale_o, rd_n_o, wr_n_o} = 4'hB;
    addr_o = 10'h000;
    data_o = 8'h00;
  end

  // One bus cycle; in multiplexed mode the low byte is strobed in first.
  task automatic access(input logic we, sel, mux, hs, input logic [9:0] pins,
                        input logic [7:0] lo, wd, output logic [7:0] rd, output logic ok);
    int n;
    @(negedge clk_i);
    addr_o = pins;
    sel_n_o = ~sel;
    if (mux)
    begin
      ale_o = 1'b1;
      data_o = lo;
      repeat (3) @(negedge clk_i);
      ale_o = 1'b0;
    end
    data_o = we ? wd : ~data_o;
    rd_n_o = we;
    wr_n_o = ~we;
    ok = 1'b0;
    n = 0;
    // Stretch the access until ready, or hold a fixed cycle length.
    if (hs)
    begin
      while (!ok && n < 40)
      begin
        @(posedge clk_i);
        ok = (ready_n_i === 1'b0);
        n++;
      end
    end
    else
    begin
      repeat (7) @(posedge clk_i);
      ok = 1'b1;
    end
    rd = bus_i;
    @(negedge clk_i);
    {sel_n_o, rd_n_o, wr_n_o} = 3'h7;
    data_o = ~data_o;
    repeat (4) @(negedge clk_i);
  endtask : access

endmodule : host_cpu_model

// ===== sim/tb_host_bus_mode_select.sv
`timescale 1ns/10ps

// Self-checking bench for the host port mode logic.
module tb_host_bus_mode_select;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      fmt = 1'b1;
  logic                      tim = 1'b1;
  logic                      param16_i = 1'b0;
  logic [7:0]                rdata_i = 8'h00;
  logic                      sel_n, ale, rd_n, wr_n, oe, rdy_n, rdy_oe, req, ready_n;
  logic [9:0]                haddr;
  logic [7:0]                hdata, dout, bus, rd;
  host_port_pkg::host_req_s  req_data, last_req;
  host_port_pkg::mode_s      mode;
  logic                      ready_seen = 1'b0;
  logic                      drive_seen = 1'b0;
  int                        req_cnt = 0;
  int                        err_count = 0;
  int                        tests_run = 0;

  // Open-drain ready with pull-up, and the shared data bus.
  assign ready_n = rdy_oe ? rdy_n : 1'b1;
  assign bus = oe ? dout : hdata;

  host_bus_mode_select uut (.clk_i(clk_i), .rst_i(rst_i), .format_strap_i(fmt),
    .timing_strap_i(tim), .device_select_n_i(sel_n), .ale_i(ale), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .address_pins_i(haddr), .data_pins_i(bus), .data_pins_o(dout),
    .data_pins_oe_o(oe), .cycle_ready_n_o(rdy_n), .cycle_ready_n_oe_o(rdy_oe),
    .req_o(req), .req_data_o(req_data), .param16_i(param16_i), .rdata_i(rdata_i),
    .mode_o(mode));

  host_cpu_model host (.clk_i(clk_i), .ready_n_i(ready_n), .bus_i(bus), .sel_n_o(sel_n),
    .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(haddr), .data_o(hdata));

  // Clock of 5 ns period.
  always #2.5 clk_i = ~clk_i;

  // Records requests and any drive of data or ready.
  always @(posedge clk_i)
  begin
    if (req === 1'b1)
    begin
      req_cnt <= req_cnt + 1;
      last_req <= req_data;
    end
    if (rdy_oe === 1'b1) ready_seen <= 1'b1;
    if (oe === 1'b1) drive_seen <= 1'b1;
  end

  task automatic check_val(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : check_val

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Resets with the given straps and checks the captured mode.
  task automatic do_reset(input logic f, t);
    @(negedge clk_i);
    {fmt, tim, rst_i} = {f, t, 1'b1};
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check_val(mode, {f, t});
    ready_seen = 1'b0;
  endtask : do_reset

  // One host access; a missing ready ends the run.
  task automatic go(input logic we, sel, mux, hs, input logic [9:0] pins,
                    input logic [7:0] lo, wd);
    logic ok;
    host.access(we, sel, mux, hs, pins, lo, wd, rd, ok);
    if (hs && !ok)
    begin
      err_count++;
      give_verdict();
    end
  endtask : go

  task automatic sc_sync_big();
    int c;
    do_reset(1'b1, 1'b1);
    go(1'b1, 1'b1, 1'b0, 1'b0, 10'h2A5, 8'h00, 8'h3C);
    check_val(last_req, {1'b1, 10'h2A5, 8'h3C});
    {param16_i, rdata_i} = {1'b1, 8'h5A};
    go(1'b0, 1'b1, 1'b0, 1'b0, 10'h2A4, 8'h00, 8'h00);
    check_val({last_req.we, last_req.addr}, {1'b0, 10'h2A5});
    check_val(rd, 8'h5A);
    c = req_cnt;
    drive_seen = 1'b0;
    go(1'b0, 1'b0, 1'b0, 1'b0, 10'h2A4, 8'h00, 8'h00);
    check_val(req_cnt - c, 24'h0);
    check_val(drive_seen, 1'b0);
    check_val(ready_seen, 1'b0);
  endtask : sc_sync_big

  task automatic sc_async_big();
    do_reset(1'b1, 1'b0);
    {param16_i, rdata_i} = {1'b1, 8'hC3};
    go(1'b0, 1'b1, 1'b0, 1'b1, 10'h1FF, 8'h00, 8'h00);
    check_val({last_req.we, last_req.addr}, {1'b0, 10'h1FE});
    check_val(rd, 8'hC3);
  endtask : sc_async_big

  task automatic sc_mux();
    int c;
    logic [7:0] lo;
    do_reset(1'b0, 1'b1);
    param16_i = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      lo = 8'h40 + 8'(i);
      go(1'b1, 1'b0, 1'b1, 1'b0, 10'h001, lo, ~lo);
      check_val(last_req, {1'b1, 2'b01, lo, ~lo});
    end
    c = req_cnt;
    go(1'b1, 1'b0, 1'b1, 1'b0, 10'h104, 8'h00, 8'h11);
    check_val(req_cnt - c, 24'h0);
    rdata_i = 8'hE7;
    go(1'b0, 1'b0, 1'b1, 1'b0, 10'h000, 8'h03, 8'h00);
    check_val(rd, 8'hE7);
    check_val(ready_seen, 1'b0);
  endtask : sc_mux

  task automatic sc_async_little();
    do_reset(1'b0, 1'b0);
    param16_i = 1'b1;
    go(1'b1, 1'b1, 1'b0, 1'b1, 10'h0C7, 8'h00, 8'h66);
    check_val(last_req, {1'b1, 10'h0C7, 8'h66});
    {fmt, tim} = 2'h3;
    repeat (8) @(negedge clk_i);
    check_val(mode, 2'h0);
  endtask : sc_async_little

  // Main sequence.
  initial
  begin
    sc_sync_big();
    sc_async_big();
    sc_mux();
    sc_async_little();
    give_verdict();
  end

endmodule : tb_host_bus_mode_select
